// ### bench/sacc_afe_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Sample-and-hold and comparator front end
// ----------------------------------------------------------------
module sacc_afe_model
(
   input wire logic clock,
   input wire logic converter_powered,
   input wire logic sample_hold,
   input wire logic [3:0] channel_select,
   input wire logic [9:0] trial_code,
   input wire logic [9:0] chan_level [16],
   output logic compare_high
);
   logic [9:0] held_r;
   logic junk_r = 1'b0;

   // Capacitor tracks the input only while acquiring
   always_ff @(posedge clock)
   begin
      if (sample_hold)
      begin
         held_r <= chan_level[channel_select];
      end
      junk_r <= ~junk_r;
   end

   // Unpowered comparator output is garbage, never a stale answer
   assign compare_high = converter_powered ? (held_r >= trial_code) : junk_r;
endmodule : sacc_afe_model

// ### bench/sacc_conv_ctrl_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level properties
// ----------------------------------------------------------------
module sacc_conv_ctrl_properties
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [sacc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sleep_mode,
   input wire logic special_trigger,
   input wire logic timer_one_reset,
   input wire logic wake_request,
   input wire logic converter_powered,
   input wire logic sample_hold,
   input wire logic [3:0] channel_select,
   input wire logic cmp_ref_select,
   input wire logic fixed_ref_select,
   input wire logic positive_reference_select,
   input wire logic negative_reference_select,
   input wire logic [9:0] trial_code
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence s_ctl_wr;
      reg_wr && reg_addr == sacc_pkg::REG_CONTROL;
   endsequence
   sequence s_fmt_wr;
      reg_wr && reg_addr == sacc_pkg::REG_FORMAT;
   endsequence
   sequence s_fmt_rd;
      reg_rd && reg_addr == sacc_pkg::REG_FORMAT;
   endsequence

   property p_off_on_clear;
      s_ctl_wr ##0 !reg_wdata[0] |=> !converter_powered && !sample_hold;
   endproperty
   property p_hold_needs_power;
      !converter_powered |-> !sample_hold;
   endproperty
   property p_go_starts;
      s_ctl_wr ##0 (reg_wdata[1:0] == 2'h3 && sample_hold) |=> !sample_hold;
   endproperty
   property p_reset_clear;
      $fell(srst) |-> !converter_powered && !sample_hold && trial_code == 10'h000
         && channel_select == 4'h0;
   endproperty
   property p_trig_timer;
      special_trigger && converter_powered |=> timer_one_reset;
   endproperty
   property p_timer_cause;
      timer_one_reset |-> $past(special_trigger);
   endproperty
   property p_ref_route;
      cmp_ref_select == (channel_select == sacc_pkg::CHAN_CMP_REF)
         && fixed_ref_select == (channel_select == sacc_pkg::CHAN_FIXED_REF);
   endproperty
   property p_ref_follow;
      s_fmt_wr |=> positive_reference_select == $past(reg_wdata[4])
         && negative_reference_select == $past(reg_wdata[5]);
   endproperty
   property p_unused_zero;
      s_fmt_rd |=> (reg_rdata & 8'h4F) == 8'h00;
   endproperty
   property p_wake_pulse;
      wake_request |-> $past(sleep_mode) ##1 !wake_request;
   endproperty

   a_off_on_clear: assert property (p_off_on_clear)
      else $error("converter still powered after enable cleared");
   a_hold_needs_power: assert property (p_hold_needs_power)
      else $error("acquiring while unpowered");
   a_go_starts: assert property (p_go_starts)
      else $error("start write did not leave acquisition");
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   a_trig_timer: assert property (p_trig_timer)
      else $error("trigger gave no timer clear");
   a_timer_cause: assert property (p_timer_cause)
      else $error("timer clear without trigger");
   a_ref_route: assert property (p_ref_route)
      else $error("reference selects disagree with channel");
   a_ref_follow: assert property (p_ref_follow)
      else $error("reference selects did not follow write");
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused format bits read nonzero");
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("bad wake pulse");
endmodule : sacc_conv_ctrl_properties

// ### bench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_mode = 1'b0;
   logic special_trigger = 1'b0;
   logic [7:0] reg_rdata, d, e;
   logic compare_high, timer_one_reset, wake_request, converter_powered, sample_hold;
   logic cmp_ref_select, fixed_ref_select, positive_reference_select, negative_reference_select;
   logic [3:0] channel_select;
   logic [9:0] trial_code, lvl;
   logic [9:0] chan_level [16];
   logic [31:0] seed = 32'h02937E18;
   int mismatches = 0;
   int samples_checked = 0;
   int n;

   sacc_conv_ctrl DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
      .special_trigger(special_trigger), .compare_high(compare_high),
      .timer_one_reset(timer_one_reset), .wake_request(wake_request),
      .converter_powered(converter_powered), .sample_hold(sample_hold),
      .channel_select(channel_select), .cmp_ref_select(cmp_ref_select),
      .fixed_ref_select(fixed_ref_select), .positive_reference_select(positive_reference_select),
      .negative_reference_select(negative_reference_select), .trial_code(trial_code));
   sacc_afe_model u_afe (.clock(clock), .converter_powered(converter_powered),
      .sample_hold(sample_hold), .channel_select(channel_select), .trial_code(trial_code),
      .chan_level(chan_level), .compare_high(compare_high));

   initial forever #25 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // High and low result bytes as one word
   function automatic logic [15:0] exp_res(input logic [9:0] v, input logic j);
      return j ? {6'h00, v} : {v, 6'h00};
   endfunction : exp_res
   task automatic wrap_up();
      if (mismatches == 0 && samples_checked > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // Outputs a wait can watch: 0 acquiring, 1 wake, 2 powered
   function automatic logic pick(input int sel);
      return (sel == 0) ? sample_hold : (sel == 1) ? wake_request : converter_powered;
   endfunction : pick
   // Bounded wait; running out counts as a failure
   task automatic wait_val(input int sel, input logic v, output int cyc);
      cyc = 0;
      #1;
      while (pick(sel) !== v && cyc < 3000)
      begin
         @(posedge clock);
         #1 cyc++;
      end
      if (cyc >= 3000)
      begin
         mismatches++;
         wrap_up();
      end
   endtask : wait_val
   task automatic convert(input logic [1:0] c, input logic [3:0] ch, input logic j,
                          input logic [9:0] v);
      logic [7:0] ctl;
      int tad;
      ctl = {c, ch, 2'h1};
      tad = (c == 2'h0) ? 2 : (c == 2'h1) ? 8 : (c == 2'h2) ? 32 : 80;
      chan_level[ch] = v;
      wr(sacc_pkg::REG_FORMAT, {j, 7'h00});
      wr(sacc_pkg::REG_CONTROL, ctl);
      wr(sacc_pkg::REG_EVENT, 8'h00);
      repeat (10) @(posedge clock);
      check(channel_select, ch);
      check({cmp_ref_select, fixed_ref_select}, {ch == 4'hE, ch == 4'hF});
      wr(sacc_pkg::REG_CONTROL, ctl | 8'h02);
      wait_val(0, 1'b1, n);
      check(n >= 11 * tad + 4 * (c == 2'h3) && n <= 12 * tad + 8, 1);
      rd(sacc_pkg::REG_CONTROL, d);
      check(d, ctl);
      rd(sacc_pkg::REG_EVENT, d);
      check(d[0], 1'b1);
      rd(sacc_pkg::REG_RES_HIGH, d);
      rd(sacc_pkg::REG_RES_LOW, e);
      check({d, e}, exp_res(v, j));
   endtask : convert

   initial
   begin
      for (int k = 0; k < 16; k++) chan_level[k] = 10'h155;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), d);
         check(d, 8'h00);
      end
      wr(3'h6, 8'hFF);
      rd(3'h6, d);
      check(d, 8'h00);
      wr(sacc_pkg::REG_FORMAT, 8'hFF);
      rd(sacc_pkg::REG_FORMAT, d);
      check(d, 8'hB0);
      check({positive_reference_select, negative_reference_select}, 2'h3);
      wr(sacc_pkg::REG_CONTROL, 8'h03);
      rd(sacc_pkg::REG_CONTROL, d);
      check(d, 8'h01);
      for (int i = 0; i < 10; i++)
      begin
         seed = lfsr(seed);
         lvl = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[9:0];
         convert(2'(i), (i == 2) ? 4'hE : (i == 5) ? 4'hF : seed[13:10], seed[14], lvl);
      end
      // Abort keeps old results and costs two periods
      convert(2'h2, 4'h3, 1'b1, 10'h2A5);
      wr(sacc_pkg::REG_CONTROL, 8'h8F);
      repeat (40) @(posedge clock);
      wr(sacc_pkg::REG_CONTROL, 8'h8D);
      wait_val(0, 1'b1, n);
      check(n >= 64 && n <= 100, 1);
      rd(sacc_pkg::REG_RES_HIGH, d);
      rd(sacc_pkg::REG_RES_LOW, e);
      check({d, e}, exp_res(10'h2A5, 1'b1));
      chan_level[3] = 10'h0F0;
      repeat (10) @(posedge clock);
      special_trigger <= 1'b1;
      @(posedge clock);
      special_trigger <= 1'b0;
      #1 check(timer_one_reset, 1'b1);
      wait_val(0, 1'b1, n);
      rd(sacc_pkg::REG_RES_HIGH, d);
      rd(sacc_pkg::REG_RES_LOW, e);
      check({d, e}, exp_res(10'h0F0, 1'b1));
      wr(sacc_pkg::REG_CONTROL, 8'h8F);
      wr(sacc_pkg::REG_CONTROL, 8'h8C);
      rd(sacc_pkg::REG_CONTROL, d);
      check(d, 8'h8C);
      // Sleep on a divided clock kills the conversion
      wr(sacc_pkg::REG_CONTROL, 8'h8D);
      repeat (10) @(posedge clock);
      wr(sacc_pkg::REG_CONTROL, 8'h8F);
      repeat (20) @(posedge clock);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check(converter_powered, 1'b0);
      rd(sacc_pkg::REG_CONTROL, d);
      check(d, 8'h8D);
      sleep_mode <= 1'b0;
      wr(sacc_pkg::REG_CONTROL, 8'hCD);
      wr(sacc_pkg::REG_EVENT, 8'h02);
      repeat (10) @(posedge clock);
      wr(sacc_pkg::REG_CONTROL, 8'hCF);
      sleep_mode <= 1'b1;
      wait_val(1, 1'b1, n);
      check(n >= 880, 1);
      sleep_mode <= 1'b0;
      wr(sacc_pkg::REG_EVENT, 8'h00);
      repeat (10) @(posedge clock);
      wr(sacc_pkg::REG_CONTROL, 8'hCF);
      sleep_mode <= 1'b1;
      wait_val(2, 1'b0, n);
      check(n >= 880, 1);
      rd(sacc_pkg::REG_CONTROL, d);
      check(d, 8'hCD);
      sleep_mode <= 1'b0;
      // Reset in mid-conversion
      wr(sacc_pkg::REG_CONTROL, 8'h8D);
      repeat (10) @(posedge clock);
      wr(sacc_pkg::REG_CONTROL, 8'h8F);
      repeat (20) @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd(sacc_pkg::REG_CONTROL, d);
      rd(sacc_pkg::REG_RES_LOW, e);
      check({d, e}, 16'h0000);
      wrap_up();
   end
endmodule : tb

bind sacc_conv_ctrl sacc_conv_ctrl_properties u_props (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .special_trigger(special_trigger),
   .timer_one_reset(timer_one_reset), .wake_request(wake_request),
   .converter_powered(converter_powered), .sample_hold(sample_hold),
   .channel_select(channel_select), .cmp_ref_select(cmp_ref_select),
   .fixed_ref_select(fixed_ref_select), .positive_reference_select(positive_reference_select),
   .negative_reference_select(negative_reference_select), .trial_code(trial_code));

// ### rtl/sacc_conv_ctrl.sv
`timescale 1ns/1ps

module sacc_conv_ctrl
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [sacc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sleep_mode,
   input wire logic special_trigger,
   input wire logic compare_high,
   output logic timer_one_reset,
   output logic wake_request,
   output logic converter_powered,
   output logic sample_hold,
   output logic [3:0] channel_select,
   output logic cmp_ref_select,
   output logic fixed_ref_select,
   output logic positive_reference_select,
   output logic negative_reference_select,
   output logic [sacc_pkg::RES_W-1:0] trial_code
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [3:0] chan;
      logic go;
      logic enable;
      logic justify;
      logic neg_ref;
      logic pos_ref;
      logic [7:0] res_high;
      logic [7:0] res_low;
      logic done_flag;
      logic irq_en;
      sacc_pkg::sacc_state_t state;
      logic [sacc_pkg::RES_W-1:0] trial;
      logic [3:0] bit_idx;
      logic [1:0] wait_cnt;
      logic [2:0] delay_cnt;
      logic tad_run;
      logic sleep_off;
      logic [7:0] rdata;
      logic timer_rst;
      logic wake;
      logic powered;
      logic hold;
      logic cmp_ref;
      logic fixed_ref;
   } sacc_ctrl_t;

   sacc_ctrl_t s_r;
   sacc_ctrl_t s_nxt;
   logic tad_tick;

   function automatic logic [15:0] place_result(input logic [sacc_pkg::RES_W-1:0] res,
                                                input logic right);
      if (right)
      begin
         place_result = {6'h00, res[9:8], res[7:0]};
      end
      else
      begin
         place_result = {res[9:2], res[1:0], 6'h00};
      end
   endfunction : place_result

   sacc_tad_gen u_tad
   (
      .clock(clock),
      .srst(srst),
      .run(s_r.tad_run),
      .clk_sel(s_r.clk_sel),
      .tad_tick(tad_tick)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic wr_ctrl;
      logic busy;
      logic sleep_kill;
      logic can_run;
      logic sw_abort;
      logic [sacc_pkg::RES_W-1:0] res;
      logic [15:0] placed;

      s_nxt = s_r;
      wr_ctrl = reg_wr && (reg_addr == sacc_pkg::REG_CONTROL);
      busy = (s_r.state == sacc_pkg::ST_DELAY) || (s_r.state == sacc_pkg::ST_FIRST) ||
             (s_r.state == sacc_pkg::ST_BITS);
      // Only the RC clock survives sleep; the divided system clock stops
      sleep_kill = sleep_mode && (s_r.clk_sel != sacc_pkg::CLK_RC);
      can_run = 1'b0;
      sw_abort = 1'b0;
      res = s_r.trial;
      placed = '0;
      s_nxt.timer_rst = 1'b0;
      s_nxt.wake = 1'b0;
      s_nxt.rdata = 8'h00;
      // Register writes
      if (wr_ctrl)
      begin
         s_nxt.enable = reg_wdata[sacc_pkg::CTL_ENABLE_BIT];
         s_nxt.chan = reg_wdata[sacc_pkg::CTL_CHAN_MSB:sacc_pkg::CTL_CHAN_LSB];
         s_nxt.clk_sel = reg_wdata[sacc_pkg::CTL_CLK_MSB:sacc_pkg::CTL_CLK_LSB];
         // Start only counts once the converter was already on
         if (reg_wdata[sacc_pkg::CTL_GO_BIT] && s_r.enable)
         begin
            s_nxt.go = 1'b1;
         end
         else if (!reg_wdata[sacc_pkg::CTL_GO_BIT])
         begin
            s_nxt.go = 1'b0;
            sw_abort = busy;
         end
      end
      if (reg_wr && (reg_addr == sacc_pkg::REG_FORMAT))
      begin
         s_nxt.justify = reg_wdata[sacc_pkg::FMT_JUSTIFY_BIT];
         s_nxt.neg_ref = reg_wdata[sacc_pkg::FMT_NEG_REF_BIT];
         s_nxt.pos_ref = reg_wdata[sacc_pkg::FMT_POS_REF_BIT];
      end
      if (reg_wr && (reg_addr == sacc_pkg::REG_RES_HIGH))
      begin
         s_nxt.res_high = reg_wdata;
      end
      if (reg_wr && (reg_addr == sacc_pkg::REG_RES_LOW))
      begin
         s_nxt.res_low = reg_wdata;
      end
      if (reg_wr && (reg_addr == sacc_pkg::REG_EVENT))
      begin
         s_nxt.done_flag = reg_wdata[sacc_pkg::EVT_DONE_BIT];
         s_nxt.irq_en = reg_wdata[sacc_pkg::EVT_IRQ_EN_BIT];
      end
      // Hardware trigger from the compare unit
      if (special_trigger && s_r.enable)
      begin
         s_nxt.go = 1'b1;
         s_nxt.timer_rst = 1'b1;
      end
      if (!sleep_mode)
      begin
         s_nxt.sleep_off = 1'b0;
      end
      can_run = s_nxt.enable && !s_r.sleep_off && !sleep_kill;
      // ----------------------------------------------------------------
      // Sequencer
      // ----------------------------------------------------------------
      case (s_r.state)
         sacc_pkg::ST_IDLE:
         begin
            s_nxt.tad_run = 1'b0;
            if (s_nxt.go && can_run)
            begin
               s_nxt.trial = '0;
               if (s_r.clk_sel == sacc_pkg::CLK_RC)
               begin
                  s_nxt.delay_cnt = '0;
                  s_nxt.state = sacc_pkg::ST_DELAY;
               end
               else
               begin
                  s_nxt.tad_run = 1'b1;
                  s_nxt.state = sacc_pkg::ST_FIRST;
               end
            end
            else if (s_nxt.go && !s_nxt.enable)
            begin
               s_nxt.go = 1'b0;
            end
         end
         sacc_pkg::ST_DELAY:
         begin
            if (s_r.delay_cnt == sacc_pkg::INSTR_CYCLES - 3'h1)
            begin
               s_nxt.tad_run = 1'b1;
               s_nxt.state = sacc_pkg::ST_FIRST;
            end
            else
            begin
               s_nxt.delay_cnt = s_r.delay_cnt + 3'h1;
            end
         end
         sacc_pkg::ST_FIRST:
         begin
            if (tad_tick)
            begin
               s_nxt.trial[sacc_pkg::RES_MSB_IDX] = 1'b1;
               s_nxt.bit_idx = sacc_pkg::RES_MSB_IDX;
               s_nxt.state = sacc_pkg::ST_BITS;
            end
         end
         sacc_pkg::ST_BITS:
         begin
            if (tad_tick)
            begin
               res = s_r.trial;
               if (!compare_high)
               begin
                  res[s_r.bit_idx] = 1'b0;
               end
               s_nxt.trial = res;
               if (s_r.bit_idx == sacc_pkg::RES_LSB_IDX)
               begin
                  // Eleventh period ends here: one lead-in plus ten bits
                  placed = place_result(res, s_r.justify);
                  s_nxt.res_high = placed[15:8];
                  s_nxt.res_low = placed[7:0];
                  s_nxt.go = 1'b0;
                  s_nxt.done_flag = 1'b1;
                  s_nxt.tad_run = 1'b0;
                  s_nxt.state = sacc_pkg::ST_IDLE;
                  if (sleep_mode && s_r.irq_en)
                  begin
                     s_nxt.wake = 1'b1;
                  end
                  else if (sleep_mode)
                  begin
                     s_nxt.sleep_off = 1'b1;
                  end
               end
               else
               begin
                  s_nxt.trial[s_r.bit_idx - 4'h1] = 1'b1;
                  s_nxt.bit_idx = s_r.bit_idx - 4'h1;
               end
            end
         end
         sacc_pkg::ST_ABORT_WAIT:
         begin
            // Divider restarts here, so both periods are whole; a tick in flight is ignored
            s_nxt.tad_run = 1'b1;
            if (tad_tick && s_r.tad_run)
            begin
               if (s_r.wait_cnt == sacc_pkg::ABORT_TADS - 2'h1)
               begin
                  s_nxt.tad_run = 1'b0;
                  s_nxt.state = sacc_pkg::ST_IDLE;
               end
               else
               begin
                  s_nxt.wait_cnt = s_r.wait_cnt + 2'h1;
               end
            end
         end
         default:
         begin
            s_nxt.tad_run = 1'b0;
            s_nxt.state = sacc_pkg::ST_IDLE;
         end
      endcase
      // Completion in the same cycle as a software clear wins
      if (busy && (s_nxt.state != sacc_pkg::ST_IDLE))
      begin
         if (!s_nxt.enable || sleep_kill)
         begin
            s_nxt.go = 1'b0;
            s_nxt.tad_run = 1'b0;
            s_nxt.state = sacc_pkg::ST_IDLE;
         end
         else if (sw_abort)
         begin
            s_nxt.wait_cnt = '0;
            s_nxt.tad_run = 1'b0;
            s_nxt.state = sacc_pkg::ST_ABORT_WAIT;
         end
      end
      if ((s_r.state == sacc_pkg::ST_ABORT_WAIT) && (!s_nxt.enable || sleep_kill))
      begin
         s_nxt.tad_run = 1'b0;
         s_nxt.state = sacc_pkg::ST_IDLE;
      end
      // Front-end controls; enable bit itself is never touched by sleep
      s_nxt.powered = s_nxt.enable && !s_nxt.sleep_off && !sleep_kill;
      s_nxt.hold = s_nxt.powered && (s_nxt.state == sacc_pkg::ST_IDLE);
      s_nxt.cmp_ref = (s_nxt.chan == sacc_pkg::CHAN_CMP_REF);
      s_nxt.fixed_ref = (s_nxt.chan == sacc_pkg::CHAN_FIXED_REF);
      // ----------------------------------------------------------------
      // Read port
      // ----------------------------------------------------------------
      if (reg_rd)
      begin
         case (reg_addr)
            sacc_pkg::REG_CONTROL:
               s_nxt.rdata = {s_r.clk_sel, s_r.chan, s_r.go, s_r.enable};
            sacc_pkg::REG_FORMAT:
               s_nxt.rdata = {s_r.justify, 1'b0, s_r.neg_ref, s_r.pos_ref, 4'h0};
            sacc_pkg::REG_RES_HIGH:
               s_nxt.rdata = s_r.res_high;
            sacc_pkg::REG_RES_LOW:
               s_nxt.rdata = s_r.res_low;
            sacc_pkg::REG_EVENT:
               s_nxt.rdata = {6'h00, s_r.irq_en, s_r.done_flag};
            default:
               s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_r <= '0;
         s_r.clk_sel <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_CLK_MSB:sacc_pkg::CTL_CLK_LSB];
         s_r.chan <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_CHAN_MSB:sacc_pkg::CTL_CHAN_LSB];
         s_r.justify <= sacc_pkg::FORMAT_RESET[sacc_pkg::FMT_JUSTIFY_BIT];
         s_r.res_high <= sacc_pkg::RESULT_RESET;
         s_r.res_low <= sacc_pkg::RESULT_RESET;
         s_r.state <= sacc_pkg::ST_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign timer_one_reset = s_r.timer_rst;
   assign wake_request = s_r.wake;
   assign converter_powered = s_r.powered;
   assign sample_hold = s_r.hold;
   assign channel_select = s_r.chan;
   assign cmp_ref_select = s_r.cmp_ref;
   assign fixed_ref_select = s_r.fixed_ref;
   assign positive_reference_select = s_r.pos_ref;
   assign negative_reference_select = s_r.neg_ref;
   assign trial_code = s_r.trial;

endmodule : sacc_conv_ctrl

// ### rtl/sacc_pkg.sv
package sacc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] REG_CONTROL = 3'h0;
   localparam logic [2:0] REG_FORMAT = 3'h1;
   localparam logic [2:0] REG_RES_HIGH = 3'h2;
   localparam logic [2:0] REG_RES_LOW = 3'h3;
   localparam logic [2:0] REG_EVENT = 3'h4;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_GO_BIT = 1;
   localparam int CTL_CHAN_LSB = 2;
   localparam int CTL_CHAN_MSB = 5;
   localparam int CTL_CLK_LSB = 6;
   localparam int CTL_CLK_MSB = 7;
   localparam int FMT_POS_REF_BIT = 4;
   localparam int FMT_NEG_REF_BIT = 5;
   localparam int FMT_JUSTIFY_BIT = 7;
   localparam int EVT_DONE_BIT = 0;
   localparam int EVT_IRQ_EN_BIT = 1;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Clock selections and channel codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CLK_DIV2 = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_RC = 2'h3;
   localparam logic [3:0] CHAN_LAST_ANALOG = 4'hD;
   localparam logic [3:0] CHAN_CMP_REF = 4'hE;
   localparam logic [3:0] CHAN_FIXED_REF = 4'hF;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int RC_TAD_NS = 4000;
   localparam int INSTR_NS = 200;
   localparam int DIV_W = 7;
   localparam logic [DIV_W-1:0] DIV2_CYCLES = 7'h02;
   localparam logic [DIV_W-1:0] DIV8_CYCLES = 7'h08;
   localparam logic [DIV_W-1:0] DIV32_CYCLES = 7'h20;
   localparam logic [DIV_W-1:0] RC_CYCLES =
      DIV_W'((RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] INSTR_CYCLES =
      3'((INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] ABORT_TADS = 2'h2;
   localparam int RES_W = 10;
   localparam logic [3:0] RES_MSB_IDX = 4'h9;
   localparam logic [3:0] RES_LSB_IDX = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DELAY,
      ST_FIRST,
      ST_BITS,
      ST_ABORT_WAIT
   } sacc_state_t;

endpackage : sacc_pkg

// ### rtl/sacc_tad_gen.sv
`timescale 1ns/1ps

module sacc_tad_gen
(
   input wire logic clock,
   input wire logic srst,
   input wire logic run,
   input wire logic [1:0] clk_sel,
   output logic tad_tick
);

   typedef struct packed {
      logic [sacc_pkg::DIV_W-1:0] cnt;
      logic tick;
   } sacc_tad_t;

   sacc_tad_t s_r;
   sacc_tad_t s_nxt;

   function automatic logic [sacc_pkg::DIV_W-1:0] tad_len(input logic [1:0] sel);
      case (sel)
         sacc_pkg::CLK_DIV2: tad_len = sacc_pkg::DIV2_CYCLES;
         sacc_pkg::CLK_DIV8: tad_len = sacc_pkg::DIV8_CYCLES;
         sacc_pkg::CLK_DIV32: tad_len = sacc_pkg::DIV32_CYCLES;
         default: tad_len = sacc_pkg::RC_CYCLES;
      endcase
   endfunction : tad_len

   // Phase restarts whenever run drops, so the first tick is a full period away
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!run)
      begin
         s_nxt.cnt = '0;
      end
      else if (s_r.cnt == tad_len(clk_sel) - 7'h01)
      begin
         s_nxt.cnt = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign tad_tick = s_r.tick;

endmodule : sacc_tad_gen
